// File: include/pma_pkg.sv
package pma_pkg;

  // Byte-register addresses of the management path inside the device.
  localparam logic [7:0] PMA_ADR_PHY_REG_SELECT = 8'h14;
  localparam logic [7:0] PMA_ADR_WRITE_DATA_LOW = 8'h16;
  localparam logic [7:0] PMA_ADR_WRITE_DATA_HIGH = 8'h17;
  localparam logic [7:0] PMA_ADR_MGMT_COMMAND = 8'h12;
  localparam logic [7:0] PMA_ADR_MGMT_STATE = 8'h0a;
  localparam logic [7:0] PMA_ADR_READ_DATA_LOW = 8'h18;
  localparam logic [7:0] PMA_ADR_READ_DATA_HIGH = 8'h19;

  // Field positions and values.
  localparam int PMA_CMD_SINGLE_READ_BIT = 0;
  localparam int PMA_CMD_SCAN_BIT = 1;
  localparam int PMA_STATE_BUSY_BIT = 0;
  localparam int PMA_STATE_INVALID_BIT = 2;
  localparam logic [7:0] PMA_CMD_IDLE = 8'h00;
  localparam logic [7:0] PMA_CMD_READ = 8'h01 << PMA_CMD_SINGLE_READ_BIT;
  localparam logic [7:0] PMA_CMD_SCAN = 8'h01 << PMA_CMD_SCAN_BIT;
  localparam int PMA_PHY_ADDR_W = 5;
  localparam logic [15:0] PMA_DATA_RESET = 16'h0000;

  // Management transaction time, rounded up to whole clock cycles.
  localparam real PMA_OP_TIME_US = 10.24;
  localparam real PMA_CLK_PERIOD_NS = 10.0;
  localparam int PMA_OP_CYC = int'($ceil(PMA_OP_TIME_US * 1000.0 / PMA_CLK_PERIOD_NS - 0.001));
  localparam int PMA_TMR_W = 11;
  localparam logic [PMA_TMR_W-1:0] PMA_OP_CYC_W = PMA_OP_CYC[PMA_TMR_W-1:0];

  typedef enum logic [2:0] {
    PMA_OP_WRITE = 3'h0,
    PMA_OP_READ = 3'h1,
    PMA_OP_MODIFY = 3'h2,
    PMA_OP_SCAN_START = 3'h3,
    PMA_OP_SCAN_STOP = 3'h4,
    PMA_OP_SAMPLE = 3'h5
  } pma_op_e;

  typedef enum logic [11:0] {
    PMA_ST_IDLE = 12'h001,
    PMA_ST_SEL = 12'h002,
    PMA_ST_WLO = 12'h004,
    PMA_ST_WHI = 12'h008,
    PMA_ST_CMD = 12'h010,
    PMA_ST_WAIT = 12'h020,
    PMA_ST_POLL = 12'h040,
    PMA_ST_CLR = 12'h080,
    PMA_ST_RLO = 12'h100,
    PMA_ST_RHI = 12'h200,
    PMA_ST_RLO2 = 12'h400,
    PMA_ST_DONE = 12'h800
  } pma_state_e;

endpackage

// File: include/pma_if.sv
`timescale 1ns/1ps
interface pma_byte_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport master(output req, output we, output addr, output wdata, input done, input rdata);
  modport slave(input req, input we, input addr, input wdata, output done, output rdata);
endinterface

interface pma_tmr_if;
  logic start;
  logic expire;
  modport ctl(output start, input expire);
  modport tmr(input start, output expire);
endinterface

// File: rtl/pma_byte_port.sv
`timescale 1ns/1ps
module pma_byte_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Sequencer side
  pma_byte_if.slave acc,
  // Device byte-register port
  output logic devReq,
  output logic devWe,
  output logic [7:0] devAddr,
  output logic [7:0] devWdata,
  input wire logic devAck,
  input wire logic [7:0] devRdata
);

  // A request is held until the device acknowledges; a new one is only taken while idle.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      devReq <= 1'b0;
      devWe <= 1'b0;
      devAddr <= 8'h00;
      devWdata <= 8'h00;
    end else if (!devReq && acc.req) begin
      devReq <= 1'b1;
      devWe <= acc.we;
      devAddr <= acc.addr;
      devWdata <= acc.wdata;
    end else if (devAck) begin
      devReq <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc.done <= 1'b0;
      acc.rdata <= 8'h00;
    end else begin
      acc.done <= devReq && devAck;
      if (devReq && devAck && !devWe) begin
        acc.rdata <= devRdata;
      end
    end
  end

endmodule // pma_byte_port

// File: rtl/pma_wait_timer.sv
`timescale 1ns/1ps
module pma_wait_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Sequencer side
  pma_tmr_if.tmr t
);

  logic [pma_pkg::PMA_TMR_W-1:0] count_r;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= '0;
    end else if (t.start) begin
      count_r <= pma_pkg::PMA_OP_CYC_W;
    end else if (count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      t.expire <= 1'b0;
    end else begin
      t.expire <= (count_r == {{(pma_pkg::PMA_TMR_W-1){1'b0}}, 1'b1}) && !t.start;
    end
  end

endmodule // pma_wait_timer

// File: rtl/pma_phy_mgmt_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Partial updates are done as read, modify, then full write back.
// - The PHY register address is loaded into select before any write.
// - Low data byte goes to write-data low, high byte to write-data high.
// - Writing the high byte launches the write, so it always comes last.
// - No scan or single read is requested while a write is busy.
// - Scan: load address, set scan request; device starts and shows busy.
// - Two read-data bytes fetched during a scan may come from different samples.
// - During a scan no write launch and no single read is requested.
// - Cancel a scan by clearing scan request, then poll busy until clear.
// - After cancelling, wait for busy clear before any new operation.
// - Single read request starts a read; busy clears once data is obtained.
// - After a single read, clear the request bit then read both bytes.
module pma_phy_mgmt_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // User command port
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [2:0] cmdOp,
  input wire logic [4:0] cmdAddr,
  input wire logic [15:0] cmdData,
  input wire logic [15:0] cmdMask,
  // User response port
  output logic rspValid,
  output logic rspRefused,
  output logic [15:0] rspData,
  output logic scanActive,
  output logic busy,
  // Device byte-register port
  output logic devReq,
  output logic devWe,
  output logic [7:0] devAddr,
  output logic [7:0] devWdata,
  input wire logic devAck,
  input wire logic [7:0] devRdata
);

  pma_byte_if byteBus ();
  pma_tmr_if tmrBus ();

  pma_pkg::pma_state_e state_r;
  pma_pkg::pma_state_e state_nxt;
  pma_pkg::pma_op_e op_r;
  pma_pkg::pma_op_e cmdOpE;
  logic [pma_pkg::PMA_PHY_ADDR_W-1:0] addr_r;
  logic [15:0] data_r;
  logic [15:0] mask_r;
  logic [7:0] lo_r;
  logic [7:0] hi_r;
  logic pend_r;
  logic modPhase_r;
  logic scanActive_r;
  logic rspValid_r;
  logic rspRefused_r;
  logic [15:0] rspData_r;
  logic busState;
  logic kickAcc;
  logic kickTmr;
  logic stepDone;
  logic cmdLegal;
  logic cmdAccept;
  logic pollClear;
  logic [15:0] readWord;

  pma_byte_port u_byte_port (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .acc(byteBus.slave),
    .devReq(devReq),
    .devWe(devWe),
    .devAddr(devAddr),
    .devWdata(devWdata),
    .devAck(devAck),
    .devRdata(devRdata)
  );

  pma_wait_timer u_wait_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .t(tmrBus.tmr)
  );

  assign cmdOpE = pma_pkg::pma_op_e'(cmdOp);

  // Operations that launch a transaction are only taken with no scan running; scan-only ones need one.
  always_comb begin
    case (cmdOpE)
      pma_pkg::PMA_OP_WRITE,
      pma_pkg::PMA_OP_READ,
      pma_pkg::PMA_OP_MODIFY,
      pma_pkg::PMA_OP_SCAN_START: cmdLegal = !scanActive_r;
      pma_pkg::PMA_OP_SCAN_STOP,
      pma_pkg::PMA_OP_SAMPLE: cmdLegal = scanActive_r;
      default: cmdLegal = 1'b0;
    endcase
  end

  // The sequencer runs one operation at a time; during a scan only stop and sample reach the busy device.
  assign cmdReady = (state_r == pma_pkg::PMA_ST_IDLE);
  assign cmdAccept = cmdValid && cmdReady && cmdLegal;

  assign busState = (state_r != pma_pkg::PMA_ST_IDLE) && (state_r != pma_pkg::PMA_ST_WAIT) &&
                    (state_r != pma_pkg::PMA_ST_DONE);
  assign kickAcc = busState && !pend_r;
  assign kickTmr = (state_r == pma_pkg::PMA_ST_WAIT) && !pend_r;
  assign stepDone = busState ? byteBus.done : ((state_r == pma_pkg::PMA_ST_WAIT) && tmrBus.expire);
  assign tmrBus.start = kickTmr;
  assign readWord = {byteBus.rdata, lo_r};

  // A scan start waits for the first result; write, read, modify and scan stop wait for busy to drop.
  assign pollClear = (op_r == pma_pkg::PMA_OP_SCAN_START) ?
                     !byteBus.rdata[pma_pkg::PMA_STATE_INVALID_BIT] :
                     !byteBus.rdata[pma_pkg::PMA_STATE_BUSY_BIT];

  // Byte access issued by each bus state.
  always_comb begin
    byteBus.req = kickAcc;
    byteBus.we = 1'b1;
    byteBus.addr = pma_pkg::PMA_ADR_MGMT_STATE;
    byteBus.wdata = 8'h00;
    case (state_r)
      pma_pkg::PMA_ST_SEL: begin
        byteBus.addr = pma_pkg::PMA_ADR_PHY_REG_SELECT;
        byteBus.wdata = {3'h0, addr_r};
      end
      pma_pkg::PMA_ST_WLO: begin
        byteBus.addr = pma_pkg::PMA_ADR_WRITE_DATA_LOW;
        byteBus.wdata = data_r[7:0];
      end
      pma_pkg::PMA_ST_WHI: begin
        byteBus.addr = pma_pkg::PMA_ADR_WRITE_DATA_HIGH;
        byteBus.wdata = data_r[15:8];
      end
      pma_pkg::PMA_ST_CMD: begin
        byteBus.addr = pma_pkg::PMA_ADR_MGMT_COMMAND;
        byteBus.wdata = (op_r == pma_pkg::PMA_OP_SCAN_START) ? pma_pkg::PMA_CMD_SCAN :
                        pma_pkg::PMA_CMD_READ;
      end
      pma_pkg::PMA_ST_CLR: begin
        byteBus.addr = pma_pkg::PMA_ADR_MGMT_COMMAND;
        byteBus.wdata = pma_pkg::PMA_CMD_IDLE;
      end
      pma_pkg::PMA_ST_POLL: begin
        byteBus.we = 1'b0;
      end
      pma_pkg::PMA_ST_RLO,
      pma_pkg::PMA_ST_RLO2: begin
        byteBus.we = 1'b0;
        byteBus.addr = pma_pkg::PMA_ADR_READ_DATA_LOW;
      end
      pma_pkg::PMA_ST_RHI: begin
        byteBus.we = 1'b0;
        byteBus.addr = pma_pkg::PMA_ADR_READ_DATA_HIGH;
      end
      default: begin
        byteBus.req = 1'b0;
      end
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pma_pkg::PMA_ST_IDLE: begin
        if (cmdAccept) begin
          case (cmdOpE)
            pma_pkg::PMA_OP_SCAN_STOP: state_nxt = pma_pkg::PMA_ST_CLR;
            pma_pkg::PMA_OP_SAMPLE: state_nxt = pma_pkg::PMA_ST_RLO;
            default: state_nxt = pma_pkg::PMA_ST_SEL;
          endcase
        end
      end
      pma_pkg::PMA_ST_SEL: begin
        if (stepDone) begin
          state_nxt = (op_r == pma_pkg::PMA_OP_WRITE) ? pma_pkg::PMA_ST_WLO : pma_pkg::PMA_ST_CMD;
        end
      end
      pma_pkg::PMA_ST_WLO: begin
        if (stepDone) begin
          state_nxt = pma_pkg::PMA_ST_WHI;
        end
      end
      pma_pkg::PMA_ST_WHI,
      pma_pkg::PMA_ST_CMD: begin
        if (stepDone) begin
          state_nxt = pma_pkg::PMA_ST_WAIT;
        end
      end
      pma_pkg::PMA_ST_WAIT: begin
        if (stepDone) begin
          state_nxt = pma_pkg::PMA_ST_POLL;
        end
      end
      pma_pkg::PMA_ST_POLL: begin
        // Polling repeats until the flag clears; the device guarantees it does.
        if (stepDone && pollClear) begin
          case (op_r)
            pma_pkg::PMA_OP_READ: state_nxt = pma_pkg::PMA_ST_CLR;
            pma_pkg::PMA_OP_MODIFY: state_nxt = modPhase_r ? pma_pkg::PMA_ST_DONE : pma_pkg::PMA_ST_CLR;
            default: state_nxt = pma_pkg::PMA_ST_DONE;
          endcase
        end
      end
      pma_pkg::PMA_ST_CLR: begin
        if (stepDone) begin
          state_nxt = (op_r == pma_pkg::PMA_OP_SCAN_STOP) ? pma_pkg::PMA_ST_POLL : pma_pkg::PMA_ST_RLO;
        end
      end
      pma_pkg::PMA_ST_RLO: begin
        if (stepDone) begin
          state_nxt = pma_pkg::PMA_ST_RHI;
        end
      end
      pma_pkg::PMA_ST_RHI: begin
        if (stepDone) begin
          case (op_r)
            pma_pkg::PMA_OP_MODIFY: state_nxt = pma_pkg::PMA_ST_WLO;
            pma_pkg::PMA_OP_SAMPLE: state_nxt = pma_pkg::PMA_ST_RLO2;
            default: state_nxt = pma_pkg::PMA_ST_DONE;
          endcase
        end
      end
      pma_pkg::PMA_ST_RLO2: begin
        // A refresh may land between the two byte reads, so the pair is only kept once low is stable.
        if (stepDone) begin
          state_nxt = (byteBus.rdata != lo_r) ? pma_pkg::PMA_ST_RHI : pma_pkg::PMA_ST_DONE;
        end
      end
      pma_pkg::PMA_ST_DONE: begin
        state_nxt = pma_pkg::PMA_ST_IDLE;
      end
      default: begin
        state_nxt = pma_pkg::PMA_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= pma_pkg::PMA_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_r <= 1'b0;
    end else if (stepDone) begin
      pend_r <= 1'b0;
    end else if (kickAcc || kickTmr) begin
      pend_r <= 1'b1;
    end
  end

  // Captured command; the modify path replaces the stored word with the merged result.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      op_r <= pma_pkg::PMA_OP_WRITE;
      addr_r <= '0;
      data_r <= pma_pkg::PMA_DATA_RESET;
      mask_r <= pma_pkg::PMA_DATA_RESET;
      modPhase_r <= 1'b0;
    end else if (cmdAccept) begin
      op_r <= cmdOpE;
      addr_r <= cmdAddr;
      data_r <= cmdData;
      mask_r <= cmdMask;
      modPhase_r <= 1'b0;
    end else if (state_r == pma_pkg::PMA_ST_RHI && stepDone && op_r == pma_pkg::PMA_OP_MODIFY) begin
      data_r <= (readWord & ~mask_r) | (data_r & mask_r);
      modPhase_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lo_r <= 8'h00;
      hi_r <= 8'h00;
    end else if (stepDone) begin
      if (state_r == pma_pkg::PMA_ST_RLO || state_r == pma_pkg::PMA_ST_RLO2) begin
        lo_r <= byteBus.rdata;
      end
      if (state_r == pma_pkg::PMA_ST_RHI) begin
        hi_r <= byteBus.rdata;
      end
    end
  end

  // Scan state follows completed start and stop operations only.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scanActive_r <= 1'b0;
    end else if (state_r == pma_pkg::PMA_ST_DONE) begin
      if (op_r == pma_pkg::PMA_OP_SCAN_START) begin
        scanActive_r <= 1'b1;
      end else if (op_r == pma_pkg::PMA_OP_SCAN_STOP) begin
        scanActive_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rspValid_r <= 1'b0;
      rspRefused_r <= 1'b0;
      rspData_r <= pma_pkg::PMA_DATA_RESET;
    end else begin
      rspValid_r <= (state_r == pma_pkg::PMA_ST_DONE);
      rspRefused_r <= cmdValid && cmdReady && !cmdLegal;
      if (state_r == pma_pkg::PMA_ST_DONE) begin
        case (op_r)
          pma_pkg::PMA_OP_READ,
          pma_pkg::PMA_OP_SAMPLE: rspData_r <= {hi_r, lo_r};
          pma_pkg::PMA_OP_WRITE,
          pma_pkg::PMA_OP_MODIFY: rspData_r <= data_r;
          default: rspData_r <= pma_pkg::PMA_DATA_RESET;
        endcase
      end
    end
  end

  assign rspValid = rspValid_r;
  assign rspRefused = rspRefused_r;
  assign rspData = rspData_r;
  assign scanActive = scanActive_r;
  assign busy = !cmdReady;

endmodule // pma_phy_mgmt_host

// File: bench/pma_checker.sv
`timescale 1ns/1ps
module pma_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // User side
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic [2:0] cmdOp,
  input wire logic [4:0] cmdAddr,
  input wire logic [15:0] cmdData,
  input wire logic [15:0] cmdMask,
  input wire logic rspValid,
  input wire logic rspRefused,
  input wire logic [15:0] rspData,
  input wire logic scanActive,
  input wire logic busy,
  // Device side
  input wire logic devReq,
  input wire logic devWe,
  input wire logic [7:0] devAddr,
  input wire logic [7:0] devWdata,
  input wire logic devAck,
  input wire logic [7:0] devRdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  localparam int MIN_GAP = pma_pkg::PMA_OP_CYC - 1;
  logic wrHi;
  logic launch;
  logic [10:0] gap_r;
  logic [7:0] last_r;
  assign wrHi = devReq && devWe && devAddr == pma_pkg::PMA_ADR_WRITE_DATA_HIGH;
  assign launch = devAck && (wrHi || (devReq && devWe && devAddr == pma_pkg::PMA_ADR_MGMT_COMMAND
                  && devWdata != 8'h00));
  // Counts idle cycles after a launch so an early poll is caught.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_r <= 11'h000;
      last_r <= 8'h00;
    end else begin
      if (launch) gap_r <= 11'h001;
      else if (devReq) gap_r <= 11'h000;
      else if (gap_r != 11'h000 && gap_r != 11'h7ff) gap_r <= gap_r + 11'h001;
      if (devReq && devAck && devWe) last_r <= devAddr;
    end
  end
  chk_busy_end: assert property (rspValid |-> !busy && $past(busy)) else $error("response not at end of busy");
  chk_rsp_pulse: assert property (rspValid |=> !rspValid) else $error("response longer than one cycle");
  chk_rsp_excl: assert property (!(rspValid && rspRefused)) else $error("done and refused together");
  chk_refuse_cause: assert property (rspRefused |-> $past(cmdValid && cmdReady)) else $error("refusal uncaused");
  chk_scan_refuse: assert property (cmdValid && cmdReady && scanActive && cmdOp <= 3'h3 |=> rspRefused)
    else $error("op during scan not refused");
  chk_idle_refuse: assert property (cmdValid && cmdReady && !scanActive && (cmdOp == 3'h4 || cmdOp == 3'h5)
    |=> rspRefused) else $error("scan op without scan not refused");
  chk_req_hold: assert property (devReq && !devAck |=> devReq && $stable(devAddr) && $stable(devWe)
    && $stable(devWdata)) else $error("device request changed before ack");
  chk_no_launch_scan: assert property (scanActive |-> !wrHi) else $error("write launched during scan");
  chk_wait_period: assert property (devReq && gap_r != 11'h000 |-> gap_r >= MIN_GAP)
    else $error("device accessed before period ended");
  chk_write_order: assert property (wrHi && devAck |-> last_r == pma_pkg::PMA_ADR_WRITE_DATA_LOW)
    else $error("high byte not after low byte");
endmodule // pma_checker
bind pma_phy_mgmt_host pma_checker chk (.mclk, .sys_rst, .cmdValid, .cmdReady, .cmdOp, .cmdAddr, .cmdData,
  .cmdMask, .rspValid, .rspRefused, .rspData, .scanActive, .busy, .devReq, .devWe, .devAddr, .devWdata,
  .devAck, .devRdata);

// File: bench/pma_dev_model.sv
`timescale 1ns/1ps
module pma_dev_model #(
  parameter logic [31:0] IMPL_MAP = 32'h000001ff
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Byte-register port
  input wire logic devReq,
  input wire logic devWe,
  input wire logic [7:0] devAddr,
  input wire logic [7:0] devWdata,
  output logic devAck,
  output logic [7:0] devRdata
);
  logic [15:0] phy_r [32];
  logic [15:0] wrWord_r;
  logic [4:0] sel_r;
  logic [7:0] wrLo_r, rdLo_r, rdHi_r, rdVal;
  logic [1:0] cmd_r, lat_r;
  logic busy_r, invalid_r, write_r, hit;
  logic [10:0] tmr_r;
  assign hit = devReq && !devAck && lat_r == 2'h0;
  // Only busy and scan-invalid exist; nothing marks a scan refresh.
  always_comb begin
    case (devAddr)
      pma_pkg::PMA_ADR_MGMT_STATE: rdVal = {5'h00, invalid_r, 1'b0, busy_r};
      pma_pkg::PMA_ADR_READ_DATA_LOW: rdVal = rdLo_r;
      pma_pkg::PMA_ADR_READ_DATA_HIGH: rdVal = rdHi_r;
      default: rdVal = 8'h00;
    endcase
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      devAck <= 1'b0;
      lat_r <= 2'h0;
      devRdata <= 8'h00;
    end else begin
      devAck <= hit;
      // Data lines toggle between answers, so a late sample shows garbage.
      devRdata <= hit ? rdVal : ~devRdata;
      if (hit) lat_r <= 2'($urandom_range(0, 2));
      else if (devReq && !devAck) lat_r <= lat_r - 2'h1;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int j = 0; j < 32; j++) phy_r[j] <= 16'h0000;
      wrWord_r <= 16'h0000;
      sel_r <= 5'h00;
      wrLo_r <= 8'h00;
      rdLo_r <= 8'h00;
      rdHi_r <= 8'h00;
      cmd_r <= 2'h0;
      busy_r <= 1'b0;
      invalid_r <= 1'b0;
      write_r <= 1'b0;
      tmr_r <= 11'h000;
    end else begin
      if (busy_r) tmr_r <= tmr_r - 11'h001;
      if (busy_r && tmr_r == 11'h001) begin
        if (write_r) begin
          if (IMPL_MAP[sel_r]) phy_r[sel_r] <= wrWord_r;
          busy_r <= 1'b0;
        end else begin
          rdLo_r <= IMPL_MAP[sel_r] ? phy_r[sel_r][7:0] : 8'h00;
          rdHi_r <= IMPL_MAP[sel_r] ? phy_r[sel_r][15:8] : 8'h00;
          invalid_r <= 1'b0;
          // A cancelled scan still finishes its current read before busy drops.
          if (cmd_r[1]) tmr_r <= pma_pkg::PMA_OP_CYC_W;
          else busy_r <= 1'b0;
        end
      end
      if (hit && devWe) begin
        case (devAddr)
          pma_pkg::PMA_ADR_PHY_REG_SELECT: sel_r <= devWdata[4:0];
          pma_pkg::PMA_ADR_WRITE_DATA_LOW: wrLo_r <= devWdata;
          pma_pkg::PMA_ADR_WRITE_DATA_HIGH: begin
            wrWord_r <= {devWdata, wrLo_r};
            write_r <= 1'b1;
            busy_r <= 1'b1;
            tmr_r <= pma_pkg::PMA_OP_CYC_W;
          end
          pma_pkg::PMA_ADR_MGMT_COMMAND: begin
            cmd_r <= devWdata[1:0];
            if (devWdata[1:0] != 2'h0 && !busy_r) begin
              write_r <= 1'b0;
              busy_r <= 1'b1;
              tmr_r <= pma_pkg::PMA_OP_CYC_W;
              invalid_r <= devWdata[1];
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule // pma_dev_model

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic refused;
    logic [15:0] data;
  } pma_exp_s;
  logic mclk, sys_rst, cmdValid, cmdReady, rspValid, rspRefused, scanActive, busy;
  logic devReq, devWe, devAck;
  logic [2:0] cmdOp;
  logic [4:0] cmdAddr, a;
  logic [15:0] cmdData, cmdMask, rspData, w, m;
  logic [7:0] devAddr, devWdata, devRdata;
  logic [15:0] shadow [32];
  pma_exp_s expQ [$];
  pma_exp_s e;
  int bad_count, n_checks, i;
  pma_phy_mgmt_host dut (.mclk, .sys_rst, .cmdValid, .cmdReady, .cmdOp, .cmdAddr, .cmdData, .cmdMask,
    .rspValid, .rspRefused, .rspData, .scanActive, .busy, .devReq, .devWe, .devAddr, .devWdata, .devAck,
    .devRdata);
  pma_dev_model dev (.mclk, .sys_rst, .devReq, .devWe, .devAddr, .devWdata, .devAck, .devRdata);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One command at a time; the expected answer is queued before it is driven.
  task automatic run(input logic [2:0] op, input logic [4:0] ad, input logic [15:0] d, input logic [15:0] mk,
                     input logic rf, input logic [15:0] ex);
    int k;
    expQ.push_back('{rf, ex});
    @(negedge mclk);
    cmdValid = 1'b1;
    cmdOp = op;
    cmdAddr = ad;
    cmdData = d;
    cmdMask = mk;
    k = 0;
    while (cmdReady !== 1'b1 && k < 9000) begin
      @(negedge mclk);
      k++;
    end
    @(negedge mclk);
    cmdValid = 1'b0;
    cmp({15'h0000, busy}, {15'h0000, !rf});
    while (expQ.size() != 0 && k < 9000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 9000) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 16'(expQ.size()), 16'h0000);
      give_verdict();
    end
  endtask
  always @(posedge mclk) begin
    if (!sys_rst && (rspValid === 1'b1 || rspRefused === 1'b1)) begin
      if (expQ.size() == 0) cmp(16'h0001, 16'h0000);
      else begin
        e = expQ.pop_front();
        cmp({15'h0000, rspRefused}, {15'h0000, e.refused});
        if (!e.refused) cmp(rspData, e.data);
      end
    end
  end
  initial begin
    sys_rst = 1'b1;
    cmdValid = 1'b0;
    cmdOp = 3'h0;
    cmdAddr = 5'h00;
    cmdData = 16'h0000;
    cmdMask = 16'h0000;
    bad_count = 0;
    n_checks = 0;
    for (i = 0; i < 32; i++) shadow[i] = 16'h0000;
    void'($urandom(43));
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    cmp({13'h0000, busy, cmdReady, scanActive}, 16'h0002);
    $display("test reset done");
    for (i = 0; i < 6; i++) begin
      a = (i == 5) ? 5'h1f : 5'($urandom_range(0, 8));
      w = 16'($urandom);
      run(3'h0, a, w, 16'h0000, 1'b0, w);
      if (a < 5'h09) shadow[a] = w;
      run(3'h1, a, 16'h0000, 16'h0000, 1'b0, shadow[a]);
    end
    $display("test write read done");
    m = 16'($urandom);
    w = 16'($urandom);
    run(3'h2, 5'h03, w, m, 1'b0, (shadow[3] & ~m) | (w & m));
    shadow[3] = (shadow[3] & ~m) | (w & m);
    run(3'h1, 5'h03, 16'h0000, 16'h0000, 1'b0, shadow[3]);
    $display("test modify done");
    for (i = 4; i < 8; i++) run(3'(i), 5'h00, 16'h0000, 16'h0000, 1'b1, 16'h0000);
    $display("test refuse done");
    run(3'h3, 5'h03, 16'h0000, 16'h0000, 1'b0, 16'h0000);
    cmp({15'h0000, scanActive}, 16'h0001);
    for (i = 0; i < 4; i++) run(3'(i), 5'h03, 16'h1234, 16'hffff, 1'b1, 16'h0000);
    run(3'h5, 5'h03, 16'h0000, 16'h0000, 1'b0, shadow[3]);
    repeat (1100) @(negedge mclk);
    run(3'h5, 5'h03, 16'h0000, 16'h0000, 1'b0, shadow[3]);
    run(3'h4, 5'h03, 16'h0000, 16'h0000, 1'b0, 16'h0000);
    cmp({15'h0000, scanActive}, 16'h0000);
    run(3'h1, 5'h03, 16'h0000, 16'h0000, 1'b0, shadow[3]);
    $display("test scan done");
    give_verdict();
  end
endmodule // testbench
